// *** bench/test_uart_register_interface.sv ***
// Self-checking bench for the serial port register interface
`timescale 1ns/1ns
module test_uart_register_interface;
    import urif_pkg::*;
    localparam int DIVT = 8;
    localparam logic [31:0] IDLE_ST = 32'h00000086;

    logic        core_clk;
    logic        sys_rst;
    logic [3:0]  regAddr;
    logic        regRead;
    logic        regWrite;
    logic [31:0] regWdata;
    logic [31:0] regRdata;
    logic        serialIn;
    logic        serialOut;
    int          badCount;
    int          comparisons;
    int          cycles;

    urif_regs #(.DEPTH(FIFO_DEPTH), .BUF_DEP(4), .DIV(DIVT)) dut (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .regAddr  (regAddr),
        .regRead  (regRead),
        .regWrite (regWrite),
        .regWdata (regWdata),
        .regRdata (regRdata),
        .serialIn (serialIn),
        .serialOut(serialOut)
    );

    urif_line_partner #(.DIV(DIVT)) partner (
        .core_clk(core_clk),
        .lineOut (serialIn),
        .lineIn  (serialOut)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            badCount++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stopTest();
        $display("Comparisons %0d, mismatches %0d", comparisons, badCount);
        if (badCount == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask

    // Read data is registered, so it is taken just after the strobe edge
    task automatic read_check(input string what, input logic [3:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1;
        check(what, regRdata, exp);
    endtask

    // Expected status from FIFO counts plus sticky and idle flags
    function automatic logic [31:0] st(input int rc, input int tc, input logic [31:0] flags);
        st = (32'(rc) << RXCNT_LO) | (32'(tc) << TXCNT_LO) | flags;
        st[B_RXFULL] = (rc == FIFO_DEPTH);
        st[B_TXFULL] = (tc == FIFO_DEPTH);
        st[B_RXHALF] = (rc >= HALF_LEVEL);
        st[B_TXBELOW] = (tc < HALF_LEVEL);
        st[B_TXEMPTY] = (tc == 0);
        st[B_RXAVAIL] = (rc != 0);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // Whole run needs about 3000 cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            badCount++;
            stopTest();
        end
    end

    initial begin
        sys_rst = 1'b1;
        regAddr = 4'h0;
        regRead = 1'b0;
        regWrite = 1'b0;
        regWdata = 32'h0;
        badCount = 0;
        comparisons = 0;
        cycles = 0;
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        read_check("status reset", OFF_STATE, IDLE_ST);
        read_check("setup reset", OFF_SETUP, SETUP_RESET);
        read_check("empty read", OFF_CHAR, 32'h0);
        read_check("unmapped", 4'hc, 32'h0);
        reg_write(OFF_SETUP, 32'hffffffff);
        read_check("setup mask", OFF_SETUP, SETUP_RESET | SETUP_WMASK);
        reg_write(OFF_SETUP, 32'h0);
        // Transmitter held off so the FIFO fills; ninth write is dropped
        for (int i = 0; i < 9; i++) begin
            reg_write(OFF_CHAR, 32'h5a5a5aa0 + 32'(i));
            read_check("tx fill", OFF_STATE, st(0, (i < 8) ? i + 1 : 8, 32'h2));
        end
        reg_write(OFF_SETUP, 32'h1 << C_TX_EN);
        repeat (3 * DIVT) @(posedge core_clk);
        read_check("tx busy", OFF_STATE, st(0, 7, 32'h0));
        for (int i = 0; i < 4000 && partner.rxQ.size() < 8; i++) begin
            @(posedge core_clk);
        end
        for (int i = 0; i < 8; i++) begin
            check("tx char", {24'h0, partner.rxQ[i]}, 32'ha0 + 32'(i));
        end
        repeat (2 * DIVT) @(posedge core_clk);
        read_check("tx drained", OFF_STATE, IDLE_ST);
        // Eight fill the FIFO, four wait in staging, the last is lost
        reg_write(OFF_SETUP, 32'h1 << C_RX_EN);
        for (int i = 0; i < 13; i++) begin
            partner.send_char(8'h30 + 8'(i), 1'b0, 1'b0, 1'b1);
            if (i < 8) begin
                read_check("rx fill", OFF_STATE, st(i + 1, 0, 32'h2));
            end
        end
        read_check("rx lost", OFF_STATE, st(8, 0, 32'h12));
        for (int i = 0; i < 12; i++) begin
            read_check("rx char", OFF_CHAR, 32'h30 + 32'(i));
        end
        read_check("rx empty", OFF_CHAR, 32'h0);
        read_check("lost sticky", OFF_STATE, st(0, 0, 32'h12));
        reg_write(OFF_STATE, 32'h0);
        read_check("lost clear", OFF_STATE, IDLE_ST);
        partner.send_char(8'h55, 1'b0, 1'b0, 1'b0);
        read_check("framing", OFF_STATE, st(0, 0, 32'h42));
        partner.send_char(8'h00, 1'b0, 1'b0, 1'b0);
        read_check("break", OFF_STATE, st(0, 0, 32'h4a));
        reg_write(OFF_STATE, 32'hffffffff);
        read_check("status ones", OFF_STATE, st(0, 0, 32'h4a));
        // Even then odd; 8'h3c has four ones
        for (int k = 0; k < 2; k++) begin
            reg_write(OFF_SETUP, (32'h1 << C_PAR_EN) | (32'(k) << C_PAR_ODD) | 32'h1);
            partner.send_char(8'h3c, 1'b1, k[0], 1'b1);
            read_check("parity good", OFF_CHAR, 32'h3c);
            partner.send_char(8'h3c, 1'b1, ~k[0], 1'b1);
            read_check("parity bad", OFF_STATE, st(0, 0, 32'h6a));
            reg_write(OFF_STATE, 32'hffffffdf);
            read_check("parity clear", OFF_STATE, st(0, 0, 32'h4a));
        end
        reg_write(OFF_STATE, 32'h0);
        read_check("all clear", OFF_STATE, IDLE_ST);
        // Loopback with odd parity drives the transmit parity path
        reg_write(OFF_SETUP, (32'h1 << C_LOOP) | (32'h1 << C_PAR_EN) | (32'h1 << C_PAR_ODD) | 32'h3);
        reg_write(OFF_CHAR, 32'h000000c5);
        repeat (16 * DIVT) @(posedge core_clk);
        read_check("loop char", OFF_CHAR, 32'hc5);
        read_check("loop status", OFF_STATE, IDLE_ST);
        stopTest();
    end
endmodule

// *** bench/urif_line_partner.sv ***
// Remote serial transceiver model that drives and samples the line
`timescale 1ns/1ns
module urif_line_partner #(
    parameter int DIV = 8
) (
    input  wire logic core_clk,
    output logic      lineOut,
    input  wire logic lineIn
);
    logic [7:0] rxQ[$];
    logic [7:0] shift;

    // Line idles high between frames
    initial lineOut = 1'b1;

    task automatic send_bit(input logic b);
        @(posedge core_clk);
        lineOut <= b;
        repeat (DIV - 1) @(posedge core_clk);
    endtask

    // Start bit, data LSB first, optional parity, stop, then two idle bits
    task automatic send_char(input logic [7:0] d, input logic usePar, input logic parVal,
                             input logic stopVal);
        send_bit(1'b0);
        for (int i = 0; i < 8; i++) begin
            send_bit(d[i]);
        end
        if (usePar) begin
            send_bit(parVal);
        end
        send_bit(stopVal);
        send_bit(1'b1);
        send_bit(1'b1);
    endtask

    // Sample mid-bit; frames without a valid stop bit are discarded
    always begin
        @(negedge lineIn);
        repeat (DIV / 2) @(posedge core_clk);
        if (lineIn === 1'b0) begin
            for (int i = 0; i < 8; i++) begin
                repeat (DIV) @(posedge core_clk);
                shift[i] = lineIn;
            end
            repeat (DIV) @(posedge core_clk);
            if (lineIn === 1'b1) begin
                rxQ.push_back(shift);
            end
        end
    end
endmodule

// *** pkg/urif_pkg.sv ***
// Register map, field layout and reset values of the serial port registers
package urif_pkg;
    localparam int          ADDR_W         = 4;
    localparam logic [3:0]  OFF_CHAR       = 4'h0;
    localparam logic [3:0]  OFF_STATE      = 4'h4;
    localparam logic [3:0]  OFF_SETUP      = 4'h8;
    localparam int          FIFO_DEPTH     = 8;
    localparam int          HALF_LEVEL     = 4;
    localparam int          RXCNT_HI       = 31;
    localparam int          RXCNT_LO       = 26;
    localparam int          TXCNT_HI       = 25;
    localparam int          TXCNT_LO       = 20;
    localparam int          B_RXFULL       = 10;
    localparam int          B_TXFULL       = 9;
    localparam int          B_RXHALF       = 8;
    localparam int          B_TXBELOW      = 7;
    localparam int          B_FRAME        = 6;
    localparam int          B_PARITY       = 5;
    localparam int          B_LOST         = 4;
    localparam int          B_SPACE        = 3;
    localparam int          B_TXEMPTY      = 2;
    localparam int          B_TXIDLE       = 1;
    localparam int          B_RXAVAIL      = 0;
    localparam int          C_FIFOS        = 31;
    localparam int          C_LOOP         = 7;
    localparam int          C_PAR_EN       = 5;
    localparam int          C_PAR_ODD      = 4;
    localparam int          C_TX_EN        = 1;
    localparam int          C_RX_EN        = 0;
    localparam logic [31:0] SETUP_WMASK    = 32'h00007fff;
    localparam logic [31:0] SETUP_RESET    = 32'h80000000;
    localparam int          BAUD_DIV       = 16;
endpackage

// *** src/urif_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides and a registered read port
`timescale 1ns/1ns
module urif_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic                       core_clk,
    input  wire logic                       sys_rst,
    input  wire logic [WIDTH-1:0]           inData,
    input  wire logic                       inValid,
    output logic                            inReady,
    output logic [WIDTH-1:0]                outData,
    output logic                            outValid,
    input  wire logic                       outReady,
    output logic [$clog2(DEPTH+1)-1:0]      level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr;
    logic [AW-1:0]    rdPtr;
    logic [AW:0]      cnt;
    logic             doWr;
    logic             doRd;
    logic             memHas;
    ////////////////////////////////////////////////////////////////////////
    // Output word sits in a register; memory holds the rest
    assign memHas   = (cnt != '0) && !(cnt == 1 && outValid);
    assign doWr     = inValid && inReady;
    assign doRd     = (!outValid || outReady) && memHas;
    assign inReady  = (cnt != DEPTH[AW:0]);
    assign level    = cnt;
    always_ff @(posedge core_clk) begin
        if (doWr) begin
            mem[wrPtr] <= inData;
        end
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wrPtr <= '0;
        end else if (doWr) begin
            wrPtr <= wrPtr + 1'b1;
        end
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rdPtr <= '0;
            outValid <= 1'b0;
            outData <= '0;
        end else if (doRd) begin
            rdPtr <= rdPtr + 1'b1;
            outValid <= 1'b1;
            outData <= mem[rdPtr];
        end else if (outReady) begin
            outValid <= 1'b0;
        end
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + (doWr ? 1'b1 : 1'b0) - ((outValid && outReady) ? 1'b1 : 1'b0);
        end
    end
endmodule

// *** src/urif_regs.sv ***
// Serial port register interface: data, status and control registers
// Overview of operation
// - Data read returns oldest received character
// - Data write queues character for sending
// - Status 31:26 shows receive FIFO count
// - Status 25:20 shows transmit FIFO count
// - Each FIFO holds at most eight characters
// - Bit 10 high while receive FIFO full
// - Bit 9 high while transmit FIFO full
// - Bit 8 high at half receive occupancy
// - Bit 7 high while transmit below half
// - Bit 6 set on framing error
// - Bit 5 set on parity error
// - Bit 4 set on lost character
// - Bit 3 set on received break
// - Bit 2 high while transmit FIFO empty
// - Bit 1 high while transmit shifter idle
// - Bit 0 high while receive data waiting
// - Data ready once one character held
// - Errored characters never enter receive FIFO
// - Error flags sticky until written zero
// - Parity select one odd, zero even
`timescale 1ns/1ns
module urif_regs #(
    parameter int DEPTH   = urif_pkg::FIFO_DEPTH,
    parameter int BUF_DEP = 4,
    parameter int DIV     = urif_pkg::BAUD_DIV
) (
    input  wire logic                          core_clk,
    input  wire logic                          sys_rst,
    input  wire logic [urif_pkg::ADDR_W-1:0]   regAddr,
    input  wire logic                          regRead,
    input  wire logic                          regWrite,
    input  wire logic [31:0]                   regWdata,
    output logic [31:0]                        regRdata,
    input  wire logic                          serialIn,
    output logic                               serialOut
);
    import urif_pkg::*;
    localparam int CW = $clog2(DEPTH + 1);
    localparam int BW = $clog2(BUF_DEP + 1);
    localparam logic [CW-1:0] FULLC = CW'(DEPTH);
    localparam logic [CW-1:0] HALFC = CW'(DEPTH / 2);

    logic [31:0]   setup;
    logic [7:0]    rxMem [DEPTH];
    logic [CW-1:0] rxCnt;
    logic [CW-2:0] rxWp;
    logic [CW-2:0] rxRp;
    logic [7:0]    txMem [DEPTH];
    logic [CW-1:0] txCnt;
    logic [CW-2:0] txWp;
    logic [CW-2:0] txRp;
    logic          frameErr;
    logic          parErr;
    logic          lostChar;
    logic          spaceSeen;
    logic          rxS1;
    logic          rxS2;
    logic          lineIn;
    logic          tick;
    logic [7:0]    divCnt;
    logic          bufInReady;
    logic [7:0]    bufData;
    logic          bufValid;
    logic          bufTake;

    ////////////////////////////////////////////////////////////////////////
    // Bit-rate enable; divisor fixed by the DIV parameter, no scaler register
    always_ff @(posedge core_clk) begin
        if (sys_rst || divCnt == 8'(DIV - 1)) begin
            divCnt <= '0;
        end else begin
            divCnt <= divCnt + 8'h01;
        end
    end
    assign tick = (divCnt == 8'(DIV - 1));

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rxS1 <= 1'b1;
            rxS2 <= 1'b1;
        end else begin
            rxS1 <= serialIn;
            rxS2 <= rxS1;
        end
    end
    assign lineIn = setup[C_LOOP] ? serialOut : rxS2;

    ////////////////////////////////////////////////////////////////////////
    // Control register; FA is fixed, reserved bits hold zero
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            setup <= SETUP_RESET;
        end else if (regWrite && regAddr == OFF_SETUP) begin
            setup <= SETUP_RESET | (regWdata & SETUP_WMASK);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit: data write into FIFO, shifter drains one character per frame
    logic       txPop;
    logic [3:0] txBit;
    logic [9:0] txShift;
    logic       txBusy;
    logic       txPar;
    logic       txParPh;
    logic       txPush;
    assign txPush = regWrite && regAddr == OFF_CHAR && txCnt != FULLC;
    assign txPop  = !txBusy && tick && setup[C_TX_EN] && txCnt != '0;
    always_ff @(posedge core_clk) begin
        if (txPush) begin
            txMem[txWp] <= regWdata[7:0];
        end
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            txWp <= '0;
            txRp <= '0;
            txCnt <= '0;
        end else begin
            if (txPush) txWp <= txWp + 1'b1;
            if (txPop) txRp <= txRp + 1'b1;
            txCnt <= txCnt + CW'(txPush) - CW'(txPop);
        end
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            txBusy <= 1'b0;
            txShift <= '1;
            txBit <= '0;
            serialOut <= 1'b1;
            txPar <= 1'b0;
            txParPh <= 1'b0;
        end else if (txPop) begin
            txBusy <= 1'b1;
            txShift <= {1'b1, txMem[txRp], 1'b0};
            txBit <= '0;
            txPar <= setup[C_PAR_ODD] ^ (^txMem[txRp]);
            txParPh <= 1'b0;
        end else if (txBusy && tick) begin
            if (txBit == 4'd9 && setup[C_PAR_EN] && !txParPh) begin
                serialOut <= txPar;
                txParPh <= 1'b1;
            end else begin
                serialOut <= txShift[0];
                txShift <= {1'b1, txShift[9:1]};
                if (txBit == 4'd10) begin
                    txBusy <= 1'b0;
                end
                txBit <= txBit + 4'd1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive: simple once-per-tick sampler feeding the 4-word staging buffer
    logic [3:0] rxBit;
    logic [8:0] rxSh;
    logic       rxBusy;
    logic       rxDone;
    logic       rxFe;
    logic       rxPe;
    logic       rxBrk;
    logic       rxParBit;
    logic [3:0] lastBit;
    // First tick after the start bit already falls in data bit 0
    assign lastBit = setup[C_PAR_EN] ? 4'd9 : 4'd8;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rxBusy <= 1'b0;
            rxBit <= '0;
            rxSh <= '0;
            rxDone <= 1'b0;
            rxFe <= 1'b0;
            rxPe <= 1'b0;
            rxBrk <= 1'b0;
            rxParBit <= 1'b0;
        end else begin
            rxDone <= 1'b0;
            if (!rxBusy) begin
                if (!lineIn && setup[C_RX_EN] && tick) begin
                    rxBusy <= 1'b1;
                    rxBit <= '0;
                end
            end else if (tick) begin
                rxBusy <= 1'b1;
                if (rxBit < 4'd8) begin
                    rxSh <= {lineIn, rxSh[8:1]};
                end else if (rxBit == 4'd8 && setup[C_PAR_EN]) begin
                    rxParBit <= lineIn;
                end
                if (rxBit == lastBit) begin
                    rxBusy <= 1'b0;
                    rxDone <= 1'b1;
                    rxFe <= !lineIn;
                    rxBrk <= !lineIn && rxSh[8:1] == 8'h00;
                    rxPe <= setup[C_PAR_EN] &&
                            (rxParBit != (setup[C_PAR_ODD] ^ (^rxSh[8:1])));
                end
                rxBit <= rxBit + 4'd1;
            end
        end
    end
    assign bufTake = rxDone && !rxFe && !rxPe;

    urif_fifo #(
        .WIDTH (8),
        .DEPTH (BUF_DEP)
    ) u_stage (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .inData   (rxSh[8:1]),
        .inValid  (bufTake),
        .inReady  (bufInReady),
        .outData  (bufData),
        .outValid (bufValid),
        .outReady (rxCnt != FULLC),
        .level    ()
    );

    ////////////////////////////////////////////////////////////////////////
    // Receive FIFO: fed from staging buffer, drained by data reads
    logic rxPush;
    logic rxPop;
    assign rxPush = bufValid && rxCnt != FULLC;
    assign rxPop  = regRead && regAddr == OFF_CHAR && rxCnt != '0;
    always_ff @(posedge core_clk) begin
        if (rxPush) rxMem[rxWp] <= bufData;
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rxWp <= '0;
            rxRp <= '0;
            rxCnt <= '0;
        end else begin
            if (rxPush) rxWp <= rxWp + 1'b1;
            if (rxPop) rxRp <= rxRp + 1'b1;
            rxCnt <= rxCnt + CW'(rxPush) - CW'(rxPop);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky error flags: a new event wins over a clearing write
    logic stWr;
    assign stWr = regWrite && regAddr == OFF_STATE;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            frameErr <= 1'b0;
            parErr <= 1'b0;
            lostChar <= 1'b0;
            spaceSeen <= 1'b0;
        end else begin
            frameErr <= (rxDone && rxFe) | (frameErr & ~(stWr & ~regWdata[B_FRAME]));
            parErr <= (rxDone && rxPe) | (parErr & ~(stWr & ~regWdata[B_PARITY]));
            lostChar <= (bufTake && !bufInReady)
                        | (lostChar & ~(stWr & ~regWdata[B_LOST]));
            spaceSeen <= (rxDone && rxBrk) | (spaceSeen & ~(stWr & ~regWdata[B_SPACE]));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data register; level bits computed live, writes to them ignored
    logic [31:0] stateWord;
    always_comb begin
        stateWord = '0;
        stateWord[RXCNT_HI:RXCNT_LO] = 6'(rxCnt);
        stateWord[TXCNT_HI:TXCNT_LO] = 6'(txCnt);
        stateWord[B_RXFULL]  = rxCnt == FULLC;
        stateWord[B_TXFULL]  = txCnt == FULLC;
        stateWord[B_RXHALF]  = rxCnt >= HALFC;
        stateWord[B_TXBELOW] = txCnt < HALFC;
        stateWord[B_FRAME]   = frameErr;
        stateWord[B_PARITY]  = parErr;
        stateWord[B_LOST]    = lostChar;
        stateWord[B_SPACE]   = spaceSeen;
        stateWord[B_TXEMPTY] = txCnt == '0;
        stateWord[B_TXIDLE]  = !txBusy;
        stateWord[B_RXAVAIL] = rxCnt != '0;
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            regRdata <= '0;
        end else if (regRead) begin
            unique case (regAddr)
                OFF_CHAR:  regRdata <= {24'h000000, rxCnt != '0 ? rxMem[rxRp] : 8'h00};
                OFF_STATE: regRdata <= stateWord;
                OFF_SETUP: regRdata <= setup;
                default:   regRdata <= '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive full and transmit below-half flags checked against the count field of the same word read out; then storage, sticky, count and flag timing checks
    a_rx_full_flag: assert property (@(posedge core_clk) disable iff (sys_rst)
        (regRead && regAddr == OFF_STATE) |=>
        regRdata[B_RXFULL] == (regRdata[RXCNT_HI:RXCNT_LO] == 6'(DEPTH)))
        else $error("rx full flag wrong");
    a_tx_half_flag: assert property (@(posedge core_clk) disable iff (sys_rst)
        (regRead && regAddr == OFF_STATE) |=>
        regRdata[B_TXBELOW] == (regRdata[TXCNT_HI:TXCNT_LO] < 6'(DEPTH / 2)))
        else $error("tx half flag wrong");
    a_err_no_push: assert property (@(posedge core_clk) disable iff (sys_rst)
        (rxDone && (rxFe || rxPe)) |-> !bufTake) else $error("bad char stored");
    a_frame_sticky: assert property (@(posedge core_clk) disable iff (sys_rst)
        (frameErr && !stWr) |=> frameErr) else $error("frame flag dropped");
    a_tx_count_bound: assert property (@(posedge core_clk) disable iff (sys_rst)
        txCnt <= FULLC) else $error("tx count over depth");
    a_tx_push_count: assert property (@(posedge core_clk) disable iff (sys_rst)
        (txPush && !txPop) |=> txCnt == $past(txCnt) + 1) else $error("tx count miss");
    a_rx_avail_flag: assert property (@(posedge core_clk) disable iff (sys_rst)
        rxPush |=> stateWord[B_RXAVAIL]) else $error("data ready late");
    a_idle_flag: assert property (@(posedge core_clk) disable iff (sys_rst)
        txPop |=> !stateWord[B_TXIDLE]) else $error("idle flag wrong");
endmodule
